// >>> rtl/msbe_pkg.sv
// Package: constants and types shared by the metadata buffer engine ends.
// Assumes: one 40 MHz clock and a synchronous active-high reset on both ends.
package msbe_pkg;
	localparam int unsigned ADDR_W = 3;
	localparam logic [2:0] A_CTL0 = 3'h0;
	localparam logic [2:0] A_CTL1 = 3'h1;
	localparam logic [2:0] A_CONF = 3'h2;
	localparam logic [2:0] A_HDR = 3'h3;
	localparam logic [2:0] A_DATA0 = 3'h4;
	localparam logic [2:0] A_DATA1 = 3'h5;
	localparam logic [2:0] A_MISC = 3'h6;
	localparam int unsigned B_AUTOINC = 14;
	localparam int unsigned B_READY = 16;
	localparam int unsigned B_EMPTY = 24;
	localparam int unsigned B_CHDONE = 31;
	localparam int unsigned B_BLOCK = 22;
	localparam int unsigned B_AUDIO = 0;
	localparam int unsigned CNT_W = 10;
	localparam int unsigned IDX_W = 8;
	localparam int unsigned DEPTH = 256;
	localparam int unsigned PKT_DW = 8;
	localparam int unsigned MAX_PKT_PAYLOAD = 32;
	localparam int unsigned MAX_PKT_FULL = 28;
	localparam int unsigned POLL_US = 500;
	localparam int unsigned CLK_MHZ = 40;
	localparam int unsigned POLL_CYC = POLL_US * CLK_MHZ;
	localparam logic [2:0] A_HSTAT = 3'h0;
	localparam logic [2:0] A_HMASK = 3'h1;
	localparam logic [2:0] A_HCMD = 3'h2;
	localparam logic [2:0] A_HCONF = 3'h3;
	localparam logic [2:0] A_HHDR = 3'h4;
	localparam logic [2:0] A_HDATA = 3'h5;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_WRITE = 3'b001,
		ST_READY = 3'b010,
		ST_WAIT = 3'b011,
		ST_CHAIN = 3'b100
	} msbe_hstate_t;
endpackage

// >>> rtl/msbe_if.sv
// Interface: register port between the packet source and the buffer engine.
// Assumes: both modports run on the same clock.
`timescale 1ns/1ps
interface msbe_if;
	logic [2:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	modport dev (input addr, input wdata, input wr, input rd, output rdata);
	modport src (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// >>> rtl/msbe_buf.sv
// Module: one metadata buffer with its control register and empty flag.
// Assumes: the engine pulls words only while the buffer is ready.
`timescale 1ns/1ps
module msbe_buf #(
	parameter int unsigned DEPTH = msbe_pkg::DEPTH
)(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ctl_wr,
	input wire logic i_data_wr,
	input wire logic [31:0] i_wdata,
	input wire logic i_pull,
	input wire logic [7:0] i_rd_idx,
	input wire logic i_done,
	output logic [31:0] o_ctl,
	output logic [31:0] o_word,
	output logic [7:0] o_fill
);
	logic [31:0] mem [DEPTH];
	logic autoinc_r;
	logic ready_r;
	logic empty_r;
	logic [7:0] idx_r;
	logic [7:0] fill_r;
	logic [31:0] word_r;
	wire logic set_ready = i_ctl_wr & i_wdata[msbe_pkg::B_READY];
	assign o_ctl = {7'h00, empty_r, 7'h00, ready_r, 1'b0, autoinc_r, 6'h00, idx_r};
	assign o_word = word_r;
	assign o_fill = fill_r;
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			autoinc_r <= 1'b0;
			ready_r <= 1'b0;
			empty_r <= 1'b1;
			idx_r <= 8'h00;
			fill_r <= 8'h00;
		end
		else
		begin
			if (i_ctl_wr)
			begin
				autoinc_r <= i_wdata[msbe_pkg::B_AUTOINC];
				idx_r <= i_wdata[7:0];
			end
			else if (i_data_wr && autoinc_r)
				idx_r <= idx_r + 8'h01;
			if (i_data_wr)
				fill_r <= idx_r + 8'h01;
			if (set_ready)
			begin
				ready_r <= 1'b1;
				empty_r <= 1'b0;
			end
			else if (i_done)
			begin
				ready_r <= 1'b0;
				empty_r <= 1'b1;
				fill_r <= 8'h00;
			end
		end
	end
	always_ff @(posedge i_clk)
	begin
		if (i_data_wr)
			mem[idx_r] <= i_wdata;
		if (i_pull)
			word_r <= mem[i_rd_idx];
	end
endmodule // msbe_buf

// >>> rtl/msbe_dev.sv
// Module: double-buffered metadata packet engine, device end.
// Assumes: vblank and hactive inputs are synchronous; the sink takes a word per valid cycle.
`timescale 1ns/1ps
module msbe_dev (
	input wire logic I_MCLK,
	input wire logic I_RST,
	msbe_if.dev i_bus,
	input wire logic i_vblank,
	input wire logic i_hactive,
	input wire logic i_sink_ready,
	output logic o_pkt_valid,
	output logic o_pkt_hdr,
	output logic [31:0] o_pkt_data,
	output logic o_pkt_last
);
	logic [9:0] count_r;
	logic chdone_r;
	logic [31:0] hdr_r;
	logic block_r;
	logic audio_r;
	logic sel_r;
	logic busy_r;
	logic [7:0] rd_idx_r;
	logic [2:0] dw_r;
	logic hdr_phase_r;
	logic [9:0] pkt_cnt_r;
	logic pull_r;
	logic psel_r;
	logic wvld_r;
	logic lastp_r;
	logic [31:0] rdata_r;
	logic [31:0] ctl0, ctl1, word0, word1;
	logic [7:0] fill0, fill1;
	wire logic wr_ctl0 = i_bus.wr & (i_bus.addr == msbe_pkg::A_CTL0);
	wire logic wr_ctl1 = i_bus.wr & (i_bus.addr == msbe_pkg::A_CTL1);
	wire logic wr_d0 = i_bus.wr & (i_bus.addr == msbe_pkg::A_DATA0);
	wire logic wr_d1 = i_bus.wr & (i_bus.addr == msbe_pkg::A_DATA1);
	wire logic wr_conf = i_bus.wr & (i_bus.addr == msbe_pkg::A_CONF);
	wire logic rdy0 = ctl0[msbe_pkg::B_READY];
	wire logic rdy1 = ctl1[msbe_pkg::B_READY];
	wire logic cur_rdy = sel_r ? rdy1 : rdy0;
	wire logic [7:0] cur_fill = sel_r ? fill1 : fill0;
	// Audio keeps the packets out of horizontal blanking.
	wire logic slot = i_vblank & (~audio_r | i_hactive);
	// A register-header packet is pulled only after its header has gone out.
	wire logic can_pull = cur_rdy & slot & i_sink_ready & ~hdr_phase_r & (busy_r | block_r);
	wire logic buf_end = (rd_idx_r + 8'h01) == cur_fill;
	wire logic pkt_end = (dw_r == 3'(msbe_pkg::PKT_DW - 1));
	wire logic chain_end = block_r ? buf_end : (pkt_cnt_r + 10'h001 == count_r);
	wire logic done0 = can_pull & ~sel_r & pkt_end & (buf_end | chain_end);
	wire logic done1 = can_pull & sel_r & pkt_end & (buf_end | chain_end);
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h00000000;
		unique case (i_bus.addr)
			msbe_pkg::A_CTL0: rd_mux = ctl0;
			msbe_pkg::A_CTL1: rd_mux = ctl1;
			msbe_pkg::A_CONF: rd_mux = {chdone_r, 21'h000000, count_r};
			msbe_pkg::A_HDR: rd_mux = hdr_r;
			msbe_pkg::A_MISC: rd_mux = {9'h000, block_r, 21'h000000, audio_r};
			default: rd_mux = 32'h00000000;
		endcase
	end
	assign i_bus.rdata = rdata_r;
	msbe_buf u_metadata_buffer_zero (.i_clk(I_MCLK), .i_rst(I_RST), .i_ctl_wr(wr_ctl0), .i_data_wr(wr_d0),
		.i_wdata(i_bus.wdata), .i_pull(can_pull & ~sel_r), .i_rd_idx(rd_idx_r),
		.i_done(done0), .o_ctl(ctl0), .o_word(word0), .o_fill(fill0));
	msbe_buf u_metadata_buffer_one (.i_clk(I_MCLK), .i_rst(I_RST), .i_ctl_wr(wr_ctl1), .i_data_wr(wr_d1),
		.i_wdata(i_bus.wdata), .i_pull(can_pull & sel_r), .i_rd_idx(rd_idx_r),
		.i_done(done1), .o_ctl(ctl1), .o_word(word1), .o_fill(fill1));
	always_ff @(posedge I_MCLK)
	begin
		if (I_RST)
		begin
			count_r <= 10'h000;
			chdone_r <= 1'b0;
			hdr_r <= 32'h00000000;
			block_r <= 1'b0;
			audio_r <= 1'b0;
			rdata_r <= 32'h00000000;
		end
		else
		begin
			if (i_bus.rd)
				rdata_r <= rd_mux;
			if (wr_conf)
				count_r <= i_bus.wdata[9:0];
			if (i_bus.wr && i_bus.addr == msbe_pkg::A_HDR)
				hdr_r <= i_bus.wdata;
			if (i_bus.wr && i_bus.addr == msbe_pkg::A_MISC)
			begin
				block_r <= i_bus.wdata[msbe_pkg::B_BLOCK];
				audio_r <= i_bus.wdata[msbe_pkg::B_AUDIO];
			end
			// Completion wins over a coincident write that would clear it.
			if (can_pull && pkt_end && chain_end)
				chdone_r <= 1'b1;
			else if (wr_conf || (i_bus.wr && i_bus.addr == msbe_pkg::A_HDR))
				chdone_r <= 1'b0;
		end
	end
	always_ff @(posedge I_MCLK)
	begin
		if (I_RST)
		begin
			sel_r <= 1'b0;
			rd_idx_r <= 8'h00;
			dw_r <= 3'h0;
			pkt_cnt_r <= 10'h000;
			hdr_phase_r <= 1'b0;
			pull_r <= 1'b0;
			psel_r <= 1'b0;
			wvld_r <= 1'b0;
			lastp_r <= 1'b0;
			busy_r <= 1'b0;
			o_pkt_hdr <= 1'b0;
			o_pkt_last <= 1'b0;
			o_pkt_data <= 32'h00000000;
		end
		else
		begin
			pull_r <= can_pull;
			psel_r <= sel_r;
			o_pkt_hdr <= 1'b0;
			if (hdr_phase_r && slot && i_sink_ready)
			begin
				// Register header leads each register-header packet.
				hdr_phase_r <= 1'b0;
				o_pkt_hdr <= 1'b1;
				o_pkt_data <= hdr_r;
			end
			else if (pull_r)
				o_pkt_data <= psel_r ? word1 : word0;
			if (!block_r && cur_rdy && !busy_r && dw_r == 3'h0 && !hdr_phase_r)
			begin
				hdr_phase_r <= 1'b1;
				busy_r <= 1'b1;
			end
			wvld_r <= pull_r;
			lastp_r <= can_pull & pkt_end;
			o_pkt_last <= lastp_r;
			if (can_pull)
			begin
				dw_r <= dw_r + 3'h1;
				rd_idx_r <= rd_idx_r + 8'h01;
				if (pkt_end)
				begin
					busy_r <= 1'b0;
					pkt_cnt_r <= chain_end ? 10'h000 : pkt_cnt_r + 10'h001;
					if (buf_end || chain_end)
					begin
						rd_idx_r <= 8'h00;
						sel_r <= ~sel_r;
					end
				end
			end
		end
	end
	assign o_pkt_valid = wvld_r | o_pkt_hdr;
endmodule // msbe_dev

// >>> rtl/msbe_src.sv
// Module: packet source end that programs the engine like software would.
// Assumes: user pushes metadata words one per cycle after a start pulse.
`timescale 1ns/1ps
module msbe_src #(
	parameter int unsigned POLL_CYC = msbe_pkg::POLL_CYC
)(
	input wire logic I_MCLK,
	input wire logic I_RST,
	msbe_if.src o_bus,
	input wire logic i_wr,
	input wire logic [2:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic o_irq
);
	msbe_pkg::msbe_hstate_t st_r, st_nxt;
	logic [31:0] conf_r, hdr_r;
	logic [1:0] stat_r, mask_r;
	logic [12:0] words_r;
	logic misc_r;
	logic blk_r;
	logic aud_r;
	logic [31:0] rdata_r;
	logic [31:0] poll_r;
	logic bsel_r;
	logic go_r;
	logic [2:0] addr_r;
	logic [31:0] wd_r;
	logic wr_r, rd_r, rd_d_r;
	wire logic cmd_wr = i_wr & (i_addr == msbe_pkg::A_HCMD);
	wire logic data_wr = i_wr & (i_addr == msbe_pkg::A_HDATA);
	wire logic emp = o_bus.rdata[msbe_pkg::B_EMPTY];
	wire logic timeout = (poll_r >= POLL_CYC);
	wire logic [12:0] words_need = 13'(conf_r[msbe_pkg::CNT_W-1:0]) * 13'(msbe_pkg::PKT_DW);
	wire logic [31:0] ctl_autoinc = 32'h00000001 << msbe_pkg::B_AUTOINC;
	wire logic [31:0] ctl_ready = ctl_autoinc | (32'h00000001 << msbe_pkg::B_READY);
	wire logic [31:0] misc_word = (32'(blk_r) << msbe_pkg::B_BLOCK) | (32'(aud_r) << msbe_pkg::B_AUDIO);
	wire logic [31:0] user_rdata = (i_addr == msbe_pkg::A_HSTAT) ? {30'h0, stat_r}
		: (i_addr == msbe_pkg::A_HMASK) ? {30'h0, mask_r} : 32'h00000000;
	assign o_bus.addr = addr_r;
	assign o_bus.wdata = wd_r;
	assign o_bus.wr = wr_r;
	assign o_bus.rd = rd_r;
	assign o_rdata = rdata_r;
	assign o_irq = |(stat_r & mask_r);
	always_comb
	begin
		st_nxt = st_r;
		unique case (st_r)
			msbe_pkg::ST_IDLE: if (go_r && !misc_r) st_nxt = msbe_pkg::ST_WRITE;
			msbe_pkg::ST_WRITE: if (!go_r && words_r == words_need) st_nxt = msbe_pkg::ST_READY;
			msbe_pkg::ST_READY: st_nxt = msbe_pkg::ST_WAIT;
			msbe_pkg::ST_WAIT: if (rd_d_r && (emp || timeout)) st_nxt = msbe_pkg::ST_CHAIN;
			msbe_pkg::ST_CHAIN: st_nxt = msbe_pkg::ST_IDLE;
			default: st_nxt = msbe_pkg::ST_IDLE;
		endcase
	end
	always_ff @(posedge I_MCLK)
	begin
		if (I_RST)
		begin
			st_r <= msbe_pkg::ST_IDLE;
			conf_r <= 32'h00000000;
			hdr_r <= 32'h00000000;
			stat_r <= 2'h0;
			mask_r <= 2'h0;
			words_r <= 13'h0000;
			misc_r <= 1'b0;
			blk_r <= 1'b0;
			aud_r <= 1'b0;
			rdata_r <= 32'h00000000;
			poll_r <= 32'h00000000;
			bsel_r <= 1'b0;
			go_r <= 1'b0;
			addr_r <= 3'h0;
			wd_r <= 32'h00000000;
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			rd_d_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			rd_d_r <= rd_r;
			if (i_rd)
				rdata_r <= user_rdata;
			if (i_wr && i_addr == msbe_pkg::A_HMASK)
				mask_r <= i_wdata[1:0];
			if (i_wr && i_addr == msbe_pkg::A_HCONF)
				conf_r <= i_wdata;
			if (i_wr && i_addr == msbe_pkg::A_HHDR)
				hdr_r <= i_wdata;
			if (cmd_wr)
			begin
				go_r <= 1'b1;
				misc_r <= 1'b1;
				bsel_r <= i_wdata[0];
				blk_r <= i_wdata[1];
				aud_r <= i_wdata[2];
				wr_r <= 1'b1;
				addr_r <= msbe_pkg::A_CONF;
				wd_r <= conf_r;
			end
			else if (st_r == msbe_pkg::ST_IDLE && go_r && misc_r)
			begin
				misc_r <= 1'b0;
				wr_r <= 1'b1;
				addr_r <= msbe_pkg::A_MISC;
				wd_r <= misc_word;
			end
			else if (st_r == msbe_pkg::ST_IDLE && go_r)
			begin
				wr_r <= 1'b1;
				addr_r <= msbe_pkg::A_HDR;
				wd_r <= hdr_r;
			end
			else if (st_r == msbe_pkg::ST_WRITE && go_r)
			begin
				// Auto increment is armed before the first data word.
				go_r <= 1'b0;
				wr_r <= 1'b1;
				addr_r <= bsel_r ? msbe_pkg::A_CTL1 : msbe_pkg::A_CTL0;
				wd_r <= ctl_autoinc;
			end
			else if (st_r == msbe_pkg::ST_WRITE && data_wr)
			begin
				wr_r <= 1'b1;
				addr_r <= bsel_r ? msbe_pkg::A_DATA1 : msbe_pkg::A_DATA0;
				wd_r <= i_wdata;
				words_r <= words_r + 13'h0001;
			end
			else if (st_r == msbe_pkg::ST_READY)
			begin
				wr_r <= 1'b1;
				words_r <= 13'h0000;
				addr_r <= bsel_r ? msbe_pkg::A_CTL1 : msbe_pkg::A_CTL0;
				wd_r <= ctl_ready;
			end
			else if (st_r == msbe_pkg::ST_WAIT && !rd_r && !rd_d_r)
			begin
				rd_r <= 1'b1;
				addr_r <= bsel_r ? msbe_pkg::A_CTL1 : msbe_pkg::A_CTL0;
			end
			poll_r <= (st_r == msbe_pkg::ST_WAIT) ? poll_r + 32'h1 : 32'h0;
			if (st_r == msbe_pkg::ST_CHAIN)
				stat_r <= stat_r | {timeout, ~timeout};
			else if (i_wr && i_addr == msbe_pkg::A_HSTAT)
				stat_r <= stat_r & ~i_wdata[1:0];
		end
	end
endmodule // msbe_src

// >>> verif/msbe_chk_sva.sv
// Checker: timing rules of the register port between source and engine.
// Assumes: instantiated beside the interface, all signals wired by name.
`timescale 1ns/1ps
module msbe_chk (
	input wire logic I_MCLK,
	input wire logic I_RST,
	input wire logic [2:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata
);
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (I_RST);
	logic [1:0] busy_r;
	logic [2:0] dcnt_r;
	logic hdr_r;
	logic rv_r;
	logic ra_r;
	wire ctl_wr = wr && (addr[2:1] == 2'b00);
	wire dat_wr = wr && (addr[2:1] == 2'b10);
	wire rdy_wr = ctl_wr && wdata[msbe_pkg::B_READY];
	wire ctl_rd = rd && (addr[2:1] == 2'b00);
	// A buffer stays busy from its ready write until a poll sees it empty.
	always_ff @(posedge I_MCLK)
	begin
		if (I_RST)
		begin
			busy_r <= 2'b00;
			dcnt_r <= 3'h0;
			hdr_r <= 1'b0;
			rv_r <= 1'b0;
			ra_r <= 1'b0;
		end
		else
		begin
			rv_r <= ctl_rd;
			ra_r <= addr[0];
			if (dat_wr)
				dcnt_r <= dcnt_r + 3'h1;
			if (wr && addr == msbe_pkg::A_HDR)
				hdr_r <= 1'b1;
			else if (rdy_wr)
				hdr_r <= 1'b0;
			if (rv_r && rdata[msbe_pkg::B_EMPTY])
				busy_r[ra_r] <= 1'b0;
			if (rdy_wr)
				busy_r[addr[0]] <= 1'b1;
		end
	end
	a_no_dual_strobe: assert property (!(wr && rd))
		else $error("write and read strobes together");
	a_ready_autoinc: assert property (rdy_wr |-> wdata[msbe_pkg::B_AUTOINC])
		else $error("ready set without auto increment");
	a_whole_packets: assert property (rdy_wr |-> dcnt_r == 3'h0)
		else $error("ready set after a partial packet");
	a_fill_idle_buf: assert property (dat_wr |-> !busy_r[addr[0]])
		else $error("data written to a buffer not yet empty");
	a_hdr_before_data: assert property (dat_wr |-> hdr_r)
		else $error("data written before the header");
	a_poll_follows: assert property (rdy_wr |=> ##[0:60] ctl_rd)
		else $error("no poll of the control register after ready");
	a_rdata_holds: assert property (!$past(rd) |-> $stable(rdata))
		else $error("read data changed without a read");
	a_mapped_addr: assert property ((wr || rd) |-> addr <= msbe_pkg::A_MISC)
		else $error("access to an unmapped engine address");
	c_ready_zero: cover property (rdy_wr && !addr[0]);
	c_ready_one: cover property (rdy_wr && addr[0]);
	c_seen_empty: cover property (rv_r && rdata[msbe_pkg::B_EMPTY]);
endmodule // msbe_chk

// >>> verif/msbe_tb.sv
// Testbench: source and engine joined back to back, driven on the user side.
// Assumes: one 40 MHz clock and a short poll timeout of 50 cycles.
`timescale 1ns/1ps
module msbe_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [31:0] wdata = 32'h0;
	logic vblank = 1'b0;
	logic hactive = 1'b0;
	logic sink_rdy = 1'b0;
	logic [31:0] rdata;
	logic irq;
	logic pkt_valid;
	logic pkt_hdr;
	logic [31:0] pkt_data;
	logic pkt_last;
	logic [33:0] expq[$];
	logic [33:0] got;
	int err_count = 0;
	int compares = 0;
	int cyc = 0;
	msbe_if msbe_if_inst ();
	msbe_src #(.POLL_CYC(50)) msbe_src_inst (.I_MCLK(clk), .I_RST(rst),
		.o_bus(msbe_if_inst.src), .i_wr(wr), .i_addr(addr), .i_wdata(wdata),
		.i_rd(rd), .o_rdata(rdata), .o_irq(irq));
	msbe_dev msbe_dev_inst (.I_MCLK(clk), .I_RST(rst), .i_bus(msbe_if_inst.dev),
		.i_vblank(vblank), .i_hactive(hactive), .i_sink_ready(sink_rdy),
		.o_pkt_valid(pkt_valid), .o_pkt_hdr(pkt_hdr), .o_pkt_data(pkt_data),
		.o_pkt_last(pkt_last));
	msbe_chk msbe_chk_inst (.I_MCLK(clk), .I_RST(rst), .addr(msbe_if_inst.addr),
		.wdata(msbe_if_inst.wdata), .wr(msbe_if_inst.wr), .rd(msbe_if_inst.rd),
		.rdata(msbe_if_inst.rdata));
	always #12.5 clk = ~clk;
	task automatic check(string what, logic [33:0] exp, logic [33:0] seen);
		compares++;
		if (seen !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
			err_count++;
		end
	endtask
	task automatic give_verdict();
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic put(logic [2:0] a, logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		rd <= 1'b0;
		addr <= a;
		wdata <= d;
	endtask
	task automatic idle();
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic get(logic [2:0] a, logic [31:0] exp);
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check("rdata", {2'b00, exp}, {2'b00, rdata});
	endtask
	// Program one chain; each packet is expected as eight words, led by its header unless block mode is set.
	task automatic chain(logic b, int npk, logic blk, logic aud);
		logic [31:0] h;
		logic [31:0] d;
		h = $urandom();
		put(3'h3, 32'(npk));
		put(3'h4, h);
		put(3'h2, {29'h0, aud, blk, b});
		repeat (3) idle();
		for (int p = 0; p < npk; p++)
		begin
			if (!blk)
				expq.push_back({2'b10, h});
			for (int w = 0; w < 8; w++)
			begin
				d = $urandom();
				expq.push_back({1'b0, w == 7, d});
				put(3'h5, d);
			end
		end
		idle();
	endtask
	task automatic wait_for(bit on_irq);
		int n;
		n = 0;
		while ((on_irq ? irq !== 1'b1 : expq.size() > 0) && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000)
		begin
			$display("MISMATCH wait limit expected %0d seen %0d", 2999, n);
			err_count++;
		end
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 30000)
		begin
			$display("MISMATCH cycle limit expected %0d seen %0d", 30000, cyc);
			err_count++;
			give_verdict();
		end
		sink_rdy <= 1'(($urandom() % 4) != 0);
		hactive <= 1'($urandom());
		if (!rst && pkt_valid === 1'b1)
		begin
			got = (expq.size() > 0) ? expq.pop_front() : 34'h0;
			check("packet word", got, {pkt_hdr, pkt_last, pkt_data});
		end
	end
	initial
	begin
		void'($urandom(76));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		get(3'h0, 32'h0);
		get(3'h7, 32'h0);
		$display("test reset done");
		put(3'h1, 32'h3);
		vblank <= 1'b1;
		for (int b = 0; b < 2; b++)
		begin
			chain(b[0], b + 1, 1'b0, 1'b0);
			wait_for(1'b1);
			check("irq", 34'h1, {33'h0, irq});
			check("drained", 34'h0, 34'(expq.size()));
			get(3'h0, 32'h1);
			put(3'h0, 32'h1);
			idle();
			get(3'h0, 32'h0);
			check("irq clear", 34'h0, {33'h0, irq});
			$display("test chain on buffer %0d done", b);
		end
		vblank <= 1'b0;
		put(3'h1, 32'h1);
		chain(1'b0, 1, 1'b0, 1'b0);
		repeat (120) @(posedge clk);
		check("masked irq", 34'h0, {33'h0, irq});
		check("held in blank", 34'h9, 34'(expq.size()));
		get(3'h0, 32'h2);
		put(3'h0, 32'h2);
		put(3'h1, 32'h3);
		idle();
		vblank <= 1'b1;
		wait_for(1'b0);
		check("late drain", 34'h0, 34'(expq.size()));
		$display("test timeout done");
		chain(1'b1, 1, 1'b1, 1'b1);
		wait_for(1'b1);
		check("block irq", 34'h1, {33'h0, irq});
		check("block drained", 34'h0, 34'(expq.size()));
		get(3'h0, 32'h1);
		$display("test block mode done");
		give_verdict();
	end
endmodule // msbe_tb
